// [rtl/sfr_fault_prio.sv]
/*
  double-fault priority resolver for one channel.
  assumes inputs are already qualified as stable over a whole measurement.
*/
`timescale 1ns/1ps
module sfr_fault_prio (
  input  wire sfr_pkg::sfr_fault_t  fault_in,  // qualified faults
  input  wire logic                 perm,      // permanent cycle
  output sfr_pkg::sfr_report_t      report     // reported flags
);

  // open load is invisible while the stage is biased
  wire open_ok  = fault_in.open && !perm;
  wire gnd_any  = fault_in.gnd_src || fault_in.gnd_snk;
  // a sink-side ground short with no speaker reads as open load in the turn-on cycle
  wire snk_open = fault_in.gnd_snk && open_ok
                  && !fault_in.gnd_src && !fault_in.vcc;

  // source ground plus supply reports both; otherwise supply wins
  assign report.vcc      = fault_in.vcc;
  assign report.gnd      = fault_in.gnd_src
                           || (fault_in.gnd_snk && !fault_in.vcc
                               && !snk_open);
  // across with open is not a reachable pair; across is kept
  assign report.across   = fault_in.across && !gnd_any && !fault_in.vcc;
  assign report.open_off = open_ok && !fault_in.gnd_src && !fault_in.vcc
                           && !fault_in.across;
  assign report.perm     = perm;

endmodule

// [rtl/sfr_top.sv]
/*
  speaker fault report sequencer: measurement cycles, persistence
  qualification, priority reporting, read re-arm, offset window,
  interrupts and register port.
  assumes fault and offset inputs are synchronous to ref_clk, and a
  master that never raises both strobes at once.
*/
`timescale 1ns/1ps
module sfr_top #(
  parameter int NUM_CH      = sfr_pkg::NUM_CH,
  parameter int MEAS_CYCLES = sfr_pkg::MEAS_CYCLES,
  parameter int CNT_W       = sfr_pkg::CNT_W
) (
  input  wire logic                              ref_clk,     // 250 MHz
  input  wire logic                              rst_n,       // async reset
  input  wire sfr_pkg::sfr_bus_req_t             bus_req,     // reg request
  output logic [sfr_pkg::DATA_W-1:0]             rdata,       // read data
  input  wire sfr_pkg::sfr_fault_t [NUM_CH-1:0]  fault_ch,    // raw faults
  input  wire logic [NUM_CH-1:0]                 offset_ch,   // raw offset
  output logic                                   meas_active, // cycle busy
  output logic                                   irq          // interrupt
);

  localparam int RW = NUM_CH * sfr_pkg::CH_BYTE_W;
  localparam int FW = $bits(sfr_pkg::sfr_fault_t);

  // elaboration checks
  if (RW > sfr_pkg::DATA_W) begin : g_bad_ch
    $error("result bytes do not fit the data word");
  end
  if (MEAS_CYCLES < 1
      || longint'(MEAS_CYCLES) > (64'h1 << CNT_W)) begin : g_bad_cnt
    $error("measurement count does not fit the counter");
  end

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MEAS_CYCLES - 1);

  sfr_pkg::sfr_state_t         st_reg, st_next;
  logic [CNT_W-1:0]            cnt_reg, cnt_next;
  logic [NUM_CH*FW-1:0]        stable_reg, stable_next;
  logic                        perm_reg, perm_next;
  logic [RW-1:0]               result_reg, result_next;
  logic [NUM_CH-1:0]           off_stable_reg, off_stable_next;
  logic                        off_armed_reg, off_armed_next;
  logic [sfr_pkg::CTRL_W-1:0]  ctrl_reg, ctrl_next;
  logic [sfr_pkg::IRQ_W-1:0]   irq_stat_reg, irq_stat_next;
  logic [sfr_pkg::IRQ_W-1:0]   irq_en_reg, irq_en_next;
  logic [sfr_pkg::DATA_W-1:0]  rdata_reg, rdata_next;

  // register decode
  wire wr_ctrl   = bus_req.wr && bus_req.addr == sfr_pkg::CTRL_OFS;
  wire wr_clr    = bus_req.wr && bus_req.addr == sfr_pkg::IRQ_CLR_OFS;
  wire wr_en     = bus_req.wr && bus_req.addr == sfr_pkg::IRQ_EN_OFS;
  wire rd_result = bus_req.rd && bus_req.addr == sfr_pkg::RESULT_OFS;

  wire diag_en   = ctrl_reg[sfr_pkg::CTRL_DIAG_BIT];
  wire offset_en = ctrl_reg[sfr_pkg::CTRL_OFS_BIT];
  wire off_wbit  = bus_req.wdata[sfr_pkg::CTRL_OFS_BIT];
  wire off_rise  = wr_ctrl && off_wbit && !offset_en;

  // cycle sequencing: a read of the result restarts a held cycle
  wire in_meas  = st_reg == sfr_pkg::ST_MEAS;
  wire meas_end = in_meas && cnt_reg == CNT_LAST;
  wire rearm    = rd_result && diag_en
                  && st_reg == sfr_pkg::ST_HOLD;
  wire start    = rearm || (diag_en && st_reg == sfr_pkg::ST_IDLE);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      sfr_pkg::ST_IDLE: if (diag_en) st_next = sfr_pkg::ST_MEAS;
      sfr_pkg::ST_MEAS: if (meas_end) st_next = sfr_pkg::ST_HOLD;
      sfr_pkg::ST_HOLD: if (rearm) st_next = sfr_pkg::ST_MEAS;
      default:          st_next = sfr_pkg::ST_IDLE;
    endcase
    // nothing runs or advances with diagnostics off
    if (!diag_en) st_next = sfr_pkg::ST_IDLE;
  end

  assign cnt_next = start ? '0 : (in_meas ? cnt_reg + 1'b1 : cnt_reg);

  // turn-on cycle first, permanent cycles after it
  assign perm_next = !diag_en ? 1'b0 : (meas_end ? 1'b1 : perm_reg);

  // per-channel persistence, priority and offset window
  sfr_pkg::sfr_report_t [NUM_CH-1:0] rep_w;
  logic [RW-1:0]                     res_word;
  logic [RW-1:0]                     off_word;
  logic [NUM_CH-1:0]                 off_flag;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    wire [FW-1:0] seen = stable_reg[c*FW +: FW] & fault_ch[c];
    wire          shorted = fault_ch[c].gnd_src || fault_ch[c].gnd_snk
                            || fault_ch[c].vcc || fault_ch[c].across;

    // a fault that drops for one cycle is lost for this cycle
    assign stable_next[c*FW +: FW] = start ? {FW{1'b1}}
                                   : (in_meas ? seen
                                   : stable_reg[c*FW +: FW]);

    sfr_fault_prio u_prio (
      .fault_in (sfr_pkg::sfr_fault_t'(seen)),
      .perm     (perm_reg),
      .report   (rep_w[c])
    );

    assign res_word[c*8 +: 8] = {3'h0, rep_w[c]};

    // offset only counts while no short tripped the protection
    assign off_stable_next[c] = (rd_result || off_rise) ? 1'b1
                              : off_stable_reg[c] && offset_ch[c]
                                && !shorted;
    assign off_flag[c] = off_stable_reg[c] && off_armed_reg && offset_en;
    assign off_word[c*8 +: 8] = {5'h0, off_flag[c], 2'h0};
  end

  // the result register only changes when a cycle completes
  assign result_next = meas_end ? res_word : result_reg;

  // window opens at enable or at each read, closes at the next read
  assign off_armed_next = off_rise ? 1'b1
                        : (rd_result ? offset_en
                        : (wr_ctrl && !off_wbit ? 1'b0
                        : off_armed_reg));

  // control and interrupt registers; hardware set wins over clear
  wire [sfr_pkg::IRQ_W-1:0] evt;
  assign evt[sfr_pkg::IRQ_DONE_BIT]   = meas_end;
  assign evt[sfr_pkg::IRQ_FAULT_BIT]  = meas_end && |(res_word
                                        & {NUM_CH{sfr_pkg::REP_FAULT_MASK}});
  assign evt[sfr_pkg::IRQ_OFFSET_BIT] = rd_result && |off_flag;

  assign ctrl_next     = wr_ctrl ? bus_req.wdata[sfr_pkg::CTRL_W-1:0]
                                 : ctrl_reg;
  assign irq_en_next   = wr_en ? bus_req.wdata[sfr_pkg::IRQ_W-1:0]
                               : irq_en_reg;
  assign irq_stat_next = (irq_stat_reg
                          & ~(wr_clr ? bus_req.wdata[sfr_pkg::IRQ_W-1:0]
                                     : '0)) | evt;

  // read mux; unmapped and write-only addresses read as zero
  wire [sfr_pkg::DATA_W-1:0] rd_res  = sfr_pkg::DATA_W'(result_reg
                                                        | off_word);
  wire [sfr_pkg::DATA_W-1:0] rd_mux  =
      bus_req.addr == sfr_pkg::CTRL_OFS     ? sfr_pkg::DATA_W'(ctrl_reg) :
      bus_req.addr == sfr_pkg::RESULT_OFS   ? rd_res :
      bus_req.addr == sfr_pkg::IRQ_STAT_OFS ? sfr_pkg::DATA_W'(irq_stat_reg) :
      bus_req.addr == sfr_pkg::IRQ_EN_OFS   ? sfr_pkg::DATA_W'(irq_en_reg) :
      '0;
  assign rdata_next = bus_req.rd ? rd_mux : '0;

  // sequencer state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg     <= sfr_pkg::ST_IDLE;
      cnt_reg    <= '0;
      stable_reg <= '0;
      perm_reg   <= 1'b0;
      result_reg <= '0;
    end else begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      stable_reg <= stable_next;
      perm_reg   <= perm_next;
      result_reg <= result_next;
    end
  end

  // software-facing state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg       <= sfr_pkg::CTRL_RST;
      irq_stat_reg   <= sfr_pkg::IRQ_RST;
      irq_en_reg     <= sfr_pkg::IRQ_RST;
      off_stable_reg <= '0;
      off_armed_reg  <= 1'b0;
      rdata_reg      <= '0;
    end else begin
      ctrl_reg       <= ctrl_next;
      irq_stat_reg   <= irq_stat_next;
      irq_en_reg     <= irq_en_next;
      off_stable_reg <= off_stable_next;
      off_armed_reg  <= off_armed_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign rdata       = rdata_reg;
  assign meas_active = in_meas;
  assign irq         = |(irq_stat_reg & irq_en_reg);

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_hold_read;
    st_reg == sfr_pkg::ST_HOLD && rd_result && diag_en;
  endsequence
  sequence s_restart;
    st_reg == sfr_pkg::ST_MEAS && cnt_reg == '0;
  endsequence

  read_rearm_a: assert property (
    s_hold_read |=> s_restart
                    ##1 (cnt_reg == CNT_W'(1) || st_reg != sfr_pkg::ST_MEAS))
    else $error("read did not restart a held cycle");

  read_prev_a: assert property (
    rd_result |=> (rdata[RW-1:0] & {NUM_CH{sfr_pkg::REP_KEEP_MASK}})
                  == ($past(result_reg) & {NUM_CH{sfr_pkg::REP_KEEP_MASK}}))
    else $error("read did not return the previous result");

  diag_off_a: assert property (
    !diag_en |=> st_reg == sfr_pkg::ST_IDLE && !meas_active)
    else $error("cycle running with diagnostics off");

  first_report_a: assert property (
    meas_end && |(stable_next[FW-1:1] & 4'hf) |=> |result_reg[3:0])
    else $error("faults present but none reported");

  supply_dom_a: assert property (
    meas_end && stable_next[FW-3] && !stable_next[FW-1]
    |=> result_reg[1] && !result_reg[0] && !result_reg[3])
    else $error("supply short did not dominate");

  both_short_a: assert property (
    meas_end && stable_next[FW-1] && stable_next[FW-3]
    |=> result_reg[1:0] == 2'h3)
    else $error("source ground with supply must report both");

  perm_open_a: assert property (
    meas_end && perm_reg |=> !$rose(result_reg[2]) && !result_reg[2])
    else $error("open load reported in permanent cycle");

  persist_a: assert property (
    in_meas && !meas_end && !fault_ch[0].vcc |=> !stable_reg[FW-3])
    else $error("dropped fault kept as stable");

  offset_win_a: assert property (
    (rd_result && off_flag[0]) ##1 !bus_req.rd
    |-> rdata[sfr_pkg::REP_OFF_BIT] ##1 !rdata[sfr_pkg::REP_OFF_BIT])
    else $error("offset flag not returned at the read");

  irq_level_a: assert property (
    $rose(evt[sfr_pkg::IRQ_DONE_BIT]) && irq_en_reg[sfr_pkg::IRQ_DONE_BIT]
    && !wr_en |=> irq)
    else $error("enabled event did not raise the interrupt");

endmodule

// [shared/sfr_pkg.sv]
/*
  shared constants, register map and carrier types for the speaker fault
  report sequencer. assumes a 250 MHz single clock and a plain register
  port driven by a synchronous master.

*/
package sfr_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] RESULT_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_CLR_OFS  = 8'h0c;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFS   = 8'h10;

  // control fields
  localparam int          CTRL_W         = 2;
  localparam int          CTRL_DIAG_BIT  = 0;
  localparam int          CTRL_OFS_BIT   = 1;
  localparam logic [1:0]  CTRL_RST       = 2'h0;

  // interrupt fields
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_DONE_BIT   = 0;
  localparam int          IRQ_FAULT_BIT  = 1;
  localparam int          IRQ_OFFSET_BIT = 2;
  localparam logic [2:0]  IRQ_RST        = 3'h0;

  // result layout: one byte per channel
  localparam int          NUM_CH         = 2;
  localparam int          CH_BYTE_W      = 8;
  localparam int          REP_OFF_BIT    = 2;
  localparam logic [7:0]  REP_FAULT_MASK = 8'h0f;
  localparam logic [7:0]  REP_KEEP_MASK  = 8'hfb;

  // measurement timing
  localparam int CLK_MHZ      = 250;
  localparam int MEAS_TIME_MS = 100;
  localparam int MEAS_CYCLES  = MEAS_TIME_MS * 1000 * CLK_MHZ;
  localparam int CNT_W        = 25;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEAS,
    ST_HOLD
  } sfr_state_t;

  // raw fault indications of one channel
  typedef struct packed {
    logic gnd_src;  // positive output shorted to ground
    logic gnd_snk;  // negative output shorted to ground
    logic vcc;      // either output shorted to supply
    logic across;   // short across the speaker
    logic open;     // speaker open
  } sfr_fault_t;

  // reported byte of one channel, low five bits
  typedef struct packed {
    logic perm;      // 1: permanent cycle, 0: turn-on cycle
    logic across;
    logic open_off;  // open load (turn-on) or offset (permanent)
    logic vcc;
    logic gnd;
  } sfr_report_t;

  // one register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sfr_bus_req_t;

endpackage

// [verification/sfr_load_model.sv]
/*
  behavioural speaker load for the fault report sequencer: presents the
  requested fault and offset levels on the outputs one clock later.
  assumes the bench changes its requests right after a rising edge.
*/
`timescale 1ns/1ps
module sfr_load_model (
  input  wire logic                       ref_clk,   // bench clock
  input  wire sfr_pkg::sfr_fault_t [1:0]  want,      // requested faults
  input  wire logic [1:0]                 want_off,  // requested offset
  output sfr_pkg::sfr_fault_t [1:0]       fault_ch,  // to the block
  output logic [1:0]                      offset_ch  // to the block
);
  // the lag keeps level changes clear of the block's sampling edge;
  // element 0 is channel 0, source side on the positive output
  always_ff @(posedge ref_clk) begin
    fault_ch  <= want;
    offset_ch <= want_off;
  end
endmodule

// [verification/sfr_top_tb.sv]
/*
  self-checking bench for sfr_top: register tasks, fault pair table,
  persistence, re-arm on read, offset window and interrupts.
  assumes a short measurement cycle set through MEAS_CYCLES.
*/
`timescale 1ns/1ps
module sfr_top_tb;
  localparam int MC = 8;
  logic                       ref_clk     = 1'b0;
  logic                       rst_n       = 1'b0;
  sfr_pkg::sfr_bus_req_t      req         = '0;
  sfr_pkg::sfr_fault_t [1:0]  want        = '0;
  logic [1:0]                 want_off    = 2'h0;
  sfr_pkg::sfr_fault_t [1:0]  fault_ch;
  logic [1:0]                 offset_ch;
  logic [31:0]                rdata;
  logic                       meas_active;
  logic                       irq;
  logic [31:0]                d;
  int                         bad_count   = 0;
  int                         comparisons = 0;
  // permanent-mode pairs and open alone: fault code on both channels, byte expected
  logic [4:0] f_tab [11] = '{5'h18, 5'h14, 5'h12, 5'h11, 5'h0c, 5'h0a,
                             5'h09, 5'h06, 5'h05, 5'h03, 5'h01};
  logic [7:0] e_tab [11] = '{8'h11, 8'h13, 8'h11, 8'h11, 8'h12, 8'h11,
                             8'h11, 8'h12, 8'h12, 8'h18, 8'h10};

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  sfr_top #(.NUM_CH(2), .MEAS_CYCLES(MC), .CNT_W(25)) uut (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .bus_req     (req),
    .rdata       (rdata),
    .fault_ch    (fault_ch),
    .offset_ch   (offset_ch),
    .meas_active (meas_active),
    .irq         (irq)
  );

  sfr_load_model load (
    .ref_clk   (ref_clk),
    .want      (want),
    .want_off  (want_off),
    .fault_ch  (fault_ch),
    .offset_ch (offset_ch)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= v;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  // read data is taken in the one cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // bounded wait for the running measurement to end
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (meas_active !== 1'b0 && n < 100);
    if (n >= 100) begin
      bad_count++;
      $display("unexpected at %0t: measurement never ended", $time);
    end
  endtask

  // the first cycle sees the change mid-way, so only the second counts
  task automatic run_case(input logic [4:0] f, input logic [7:0] e);
    @(posedge ref_clk);
    want <= {f, f};
    wait_done;
    rd(sfr_pkg::RESULT_OFS);
    wait_done;
    rd(sfr_pkg::RESULT_OFS);
    check(d, {16'h0, e, e});
  endtask

  // watchdog, far beyond the expected run of about 380 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    end_of_test;
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, 0x14 unmapped; an unmapped write is ignored
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i));
      check(d, 32'h0);
    end
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14);
    check(d, 32'h0);
    wr(sfr_pkg::IRQ_EN_OFS, 32'h7);
    // turn-on cycle with a different pair on each channel
    @(posedge ref_clk);
    want <= {5'h09, 5'h14};
    wr(sfr_pkg::CTRL_OFS, 32'h1);
    rd(sfr_pkg::CTRL_OFS);
    check(d, 32'h1);
    wait_done;
    check({31'h0, irq}, 32'h1);
    rd(sfr_pkg::IRQ_STAT_OFS);
    check(d, 32'h3);
    wr(sfr_pkg::IRQ_EN_OFS, 32'h0);
    #1 check({31'h0, irq}, 32'h0);
    wr(sfr_pkg::IRQ_EN_OFS, 32'h7);
    wr(sfr_pkg::IRQ_CLR_OFS, 32'h7);
    #1 check({31'h0, irq}, 32'h0);
    rd(sfr_pkg::IRQ_STAT_OFS);
    check(d, 32'h0);
    rd(sfr_pkg::IRQ_CLR_OFS);
    check(d, 32'h0);
    // faults removed before the read still show once
    @(posedge ref_clk);
    want <= '0;
    rd(sfr_pkg::RESULT_OFS);
    check(d, 32'h0403);
    check({31'h0, meas_active}, 32'h1);
    wait_done;
    rd(sfr_pkg::RESULT_OFS);
    check(d, 32'h1010);
    for (int i = 0; i < 11; i++) begin
      run_case(f_tab[i], e_tab[i]);
    end
    // a one-cycle gap in the fault must keep it out of the result
    @(posedge ref_clk);
    want <= {5'h14, 5'h14};
    wait_done;
    rd(sfr_pkg::RESULT_OFS);
    repeat (3) @(posedge ref_clk);
    want <= '0;
    @(posedge ref_clk);
    want <= {5'h14, 5'h14};
    wait_done;
    rd(sfr_pkg::RESULT_OFS);
    check(d, 32'h1010);
    // offset window opened by the enable and closed by the read
    @(posedge ref_clk);
    want     <= '0;
    want_off <= 2'h1;
    wait_done;
    wr(sfr_pkg::IRQ_CLR_OFS, 32'h7);
    wr(sfr_pkg::CTRL_OFS, 32'h3);
    repeat (MC) @(posedge ref_clk);
    rd(sfr_pkg::RESULT_OFS);
    check(d, 32'h1014);
    rd(sfr_pkg::IRQ_STAT_OFS);
    check(d, 32'h4);
    repeat (3) @(posedge ref_clk);
    want_off <= 2'h0;
    @(posedge ref_clk);
    want_off <= 2'h1;
    wait_done;
    rd(sfr_pkg::RESULT_OFS);
    check(d, 32'h1010);
    // a short inside the offset window cancels the offset flag
    repeat (3) @(posedge ref_clk);
    want <= {5'h00, 5'h02};
    @(posedge ref_clk);
    want <= '0;
    wait_done;
    rd(sfr_pkg::RESULT_OFS);
    check(d, 32'h1010);
    // diagnostics off: engine idle, result frozen, reads do not re-arm
    wait_done;
    @(posedge ref_clk);
    want_off <= 2'h0;
    want     <= {5'h14, 5'h14};
    wr(sfr_pkg::CTRL_OFS, 32'h0);
    repeat (20) @(posedge ref_clk);
    #1 check({31'h0, meas_active}, 32'h0);
    rd(sfr_pkg::RESULT_OFS);
    check(d, 32'h1010);
    check({31'h0, meas_active}, 32'h0);
    end_of_test;
  end
endmodule
